// ===== cmos_clk_pkg.sv
// shared constants and types for the cmos status clock divider
package cmos_clk_pkg;
    localparam logic [7:0] ctrl_offset = 8'h2d;
    localparam logic [7:0] div0_offset = 8'h2e;
    localparam logic [7:0] src_offset = 8'h30;
    localparam int prediv_pos = 4;
    localparam int mux_b_pos = 2;
    localparam int mux_a_pos = 0;
    localparam int src_sel_pos = 0;
    localparam logic [7:0] ctrl_reset = 8'h0a;
    localparam logic [7:0] div0_reset = 8'h00;
    localparam logic [7:0] src_reset = 8'h00;
    localparam logic [1:0] prediv_off = 2'h0;
    localparam logic [1:0] prediv_by4 = 2'h1;
    localparam logic [1:0] prediv_by5 = 2'h2;
    localparam logic [8:0] prediv_ratio4 = 9'h004;
    localparam logic [8:0] prediv_ratio5 = 9'h005;
    localparam logic [7:0] div0_min_code = 8'h06;
    localparam logic [8:0] div0_min_ratio = 9'h006;
    typedef enum logic [1:0] {
        mux_div0 = 2'h0,
        mux_div1 = 2'h1,
        mux_status = 2'h2,
        mux_off = 2'h3
    } mux_type;
    typedef struct packed {
        logic [1:0] reserved;
        logic [1:0] prediv;
        mux_type mux_b;
        mux_type mux_a;
    } ctrl_type;
    typedef struct packed {
        logic out;
        logic oe;
    } pin_type;
endpackage

// ===== clock_div_stage.sv
// tick-driven divide-by-n stage with a roughly half-duty level output
`timescale 1ns/1ps
module clock_div_stage
    import cmos_clk_pkg::*;
#(
    parameter int W = 9
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic enable,
    input wire logic in_tick,
    input wire logic [W-1:0] ratio,
    output logic out_tick,
    output logic level
);
    // refused at elaboration: a one-bit counter cannot hold any ratio
    if (W < 2)
    begin : g_width_check
        $error("clock_div_stage: W must be at least 2");
    end

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic level_r;
    logic level_nxt;
    logic wrap;

    // >= rather than == so a ratio lowered mid-count still wraps
    assign wrap = count_r >= ratio - W'(1);
    assign out_tick = enable && in_tick && wrap;
    assign level = level_r;

    always_comb
    begin
        count_nxt = count_r;
        if (!enable)
            count_nxt = '0;
        else if (in_tick)
            count_nxt = wrap ? '0 : count_r + W'(1);
        level_nxt = enable && (count_nxt < (ratio >> 1));
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            count_r <= '0;
            level_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            level_r <= level_nxt;
        end
    end

    property p_wrap;
        @(posedge clock) disable iff (!rstn)
        out_tick |=> count_r == '0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("divider count did not wrap to zero");
endmodule // clock_div_stage

// ===== cmos_status_clock_divider.sv
// status pin clock routing, pre-divider and cmos divider 0 with registers
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
// How it works
// RULE1: the cmos dividers are fed by either synthesizer's pre-divider.
// RULE2: pre-divider bits [5:4]: 0 off, 1 by 4, 2 by 5, 3 reserved.
// RULE3: pin b source bits [3:2] pick div 0, div 1, status or off; reset 2.
// RULE4: pin a source bits [1:0] pick div 0, div 1, status or off; reset 2.
// RULE5: divider 0 is 8 bits, fed by the pre-divider; value 0 disables it.
// RULE6: values 1 to 5 of divider 0 divide by 6, larger values v by v+1.
// RULE7: software zeroes the reserved bits and avoids prediv code 3.
module cmos_status_clock_divider
    import cmos_clk_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic primary_tick,
    input wire logic second_synthesizer_tick,
    input wire logic div1_level,
    input wire logic status_a_func,
    input wire logic status_b_func,
    output logic status_pin_a_out,
    output logic status_pin_a_oe,
    output logic status_pin_b_out,
    output logic status_pin_b_oe
);
    ////////////////////////////////////////////////////////////////////////
    ctrl_type ctrl_r;
    ctrl_type ctrl_nxt;
    logic [7:0] div0_r;
    logic [7:0] div0_nxt;
    logic src_r;
    logic src_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        div0_nxt = div0_r;
        src_nxt = src_r;
        rdata_nxt = 8'h00;
        if (wr)
        begin
            // control register reserved bits are stored as written and read back; the source register keeps only bit 0
            case (addr)
                ctrl_offset: ctrl_nxt = ctrl_type'(wdata);
                div0_offset: div0_nxt = wdata;
                src_offset: src_nxt = wdata[src_sel_pos];
                default: ;
            endcase
        end
        if (rd)
        begin
            case (addr)
                ctrl_offset: rdata_nxt = ctrl_r;
                div0_offset: rdata_nxt = div0_r;
                src_offset: rdata_nxt = {7'h00, src_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_r <= ctrl_type'(ctrl_reset); // [RULE3] [RULE4]
            div0_r <= div0_reset;
            src_r <= src_reset[src_sel_pos];
            rdata_r <= 8'h00;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            div0_r <= div0_nxt;
            src_r <= src_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    logic src_tick;
    logic prediv_en;
    logic [8:0] prediv_ratio;
    logic prediv_tick;
    logic div0_en;
    logic [8:0] div0_ratio;
    logic div0_tick;
    logic div0_level;

    assign src_tick = src_r ? second_synthesizer_tick
                            : primary_tick; // [RULE1]

    always_comb
    begin
        // the reserved code is treated as off, so a stray write stays quiet
        prediv_en = 1'b1;
        prediv_ratio = prediv_ratio4;
        case (ctrl_r.prediv)
            prediv_by4: prediv_ratio = prediv_ratio4; // [RULE2]
            prediv_by5: prediv_ratio = prediv_ratio5; // [RULE2]
            default: prediv_en = 1'b0; // [RULE2]
        endcase
        div0_en = prediv_en && (div0_r != 8'h00); // [RULE5]
        if (div0_r < div0_min_code)
            div0_ratio = div0_min_ratio; // [RULE6]
        else
            div0_ratio = {1'b0, div0_r} + 9'h001; // [RULE6]
    end

    clock_div_stage #(.W(9)) u_prediv
    (
        .clock(clock),
        .rstn(rstn),
        .enable(prediv_en),
        .in_tick(src_tick),
        .ratio(prediv_ratio),
        .out_tick(prediv_tick),
        .level()
    );

    clock_div_stage #(.W(9)) u_div0
    (
        .clock(clock),
        .rstn(rstn),
        .enable(div0_en),
        .in_tick(prediv_tick), // [RULE5]
        .ratio(div0_ratio),
        .out_tick(div0_tick),
        .level(div0_level)
    );

    ////////////////////////////////////////////////////////////////////////
    mux_type mux_sel [2];
    logic status_func [2];
    pin_type pin_r [2];
    pin_type pin_nxt [2];

    assign mux_sel[0] = ctrl_r.mux_a;
    assign mux_sel[1] = ctrl_r.mux_b;
    assign status_func[0] = status_a_func;
    assign status_func[1] = status_b_func;

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_pin
            always_comb
            begin
                pin_nxt[i] = '{out: 1'b0, oe: 1'b1};
                case (mux_sel[i])
                    mux_div0: pin_nxt[i].out = div0_level; // [RULE3] [RULE4]
                    mux_div1: pin_nxt[i].out = div1_level; // [RULE3] [RULE4]
                    mux_status: pin_nxt[i].out = status_func[i];
                    default: pin_nxt[i].oe = 1'b0; // [RULE3] [RULE4]
                endcase
            end

            always_ff @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                    pin_r[i] <= '{out: 1'b0, oe: 1'b0};
                else
                    pin_r[i] <= pin_nxt[i];
            end
        end
    endgenerate

    assign status_pin_a_out = pin_r[0].out;
    assign status_pin_a_oe = pin_r[0].oe;
    assign status_pin_b_out = pin_r[1].out;
    assign status_pin_b_oe = pin_r[1].oe;

    ////////////////////////////////////////////////////////////////////////
    // helper counters: input ticks seen between output ticks, valid only
    // once a full period has passed with no register write
    logic [8:0] hp_r;
    logic hp_ok_r;
    logic [8:0] hd_r;
    logic hd_ok_r;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            hp_r <= 9'h000;
            hp_ok_r <= 1'b0;
            hd_r <= 9'h000;
            hd_ok_r <= 1'b0;
        end
        else
        begin
            if (wr)
            begin
                hp_r <= 9'h000;
                hp_ok_r <= 1'b0;
            end
            else if (prediv_tick)
            begin
                hp_r <= 9'h000;
                hp_ok_r <= 1'b1;
            end
            else if (primary_tick && !src_r
                     || second_synthesizer_tick && src_r)
                hp_r <= hp_r + 9'h001;
            if (wr)
            begin
                hd_r <= 9'h000;
                hd_ok_r <= 1'b0;
            end
            else if (div0_tick)
            begin
                hd_r <= 9'h000;
                hd_ok_r <= 1'b1;
            end
            else if (prediv_tick)
                hd_r <= hd_r + 9'h001;
        end
    end

    property p_prediv4;
        @(posedge clock) disable iff (!rstn)
        prediv_tick && hp_ok_r && ctrl_r.prediv == prediv_by4
            |-> hp_r == 9'h003;
    endproperty
    a_prediv4: assert property (p_prediv4) // [RULE1] [RULE2]
        else $error("pre-divider by 4 period wrong");

    property p_prediv5;
        @(posedge clock) disable iff (!rstn)
        prediv_tick && hp_ok_r && ctrl_r.prediv == prediv_by5
            |-> hp_r == 9'h004;
    endproperty
    a_prediv5: assert property (p_prediv5) // [RULE2]
        else $error("pre-divider by 5 period wrong");

    property p_prediv_off;
        @(posedge clock) disable iff (!rstn)
        ctrl_r.prediv == prediv_off |-> !prediv_tick ##1 !div0_level;
    endproperty
    a_prediv_off: assert property (p_prediv_off) // [RULE2]
        else $error("pre-divider ticked while off");

    property p_div0_zero;
        @(posedge clock) disable iff (!rstn)
        div0_r == 8'h00 && !wr |=> !div0_level && !div0_tick;
    endproperty
    a_div0_zero: assert property (p_div0_zero) // [RULE5]
        else $error("divider 0 ran with value zero");

    property p_div0_ratio;
        @(posedge clock) disable iff (!rstn)
        div0_tick && hd_ok_r |-> hd_r == ((div0_r < div0_min_code)
            ? div0_min_ratio - 9'h001 : {1'b0, div0_r});
    endproperty
    a_div0_ratio: assert property (p_div0_ratio) // [RULE6]
        else $error("divider 0 period wrong");

    property p_pin_off;
        @(posedge clock) disable iff (!rstn)
        ctrl_r.mux_a == mux_off |=> !status_pin_a_oe;
    endproperty
    a_pin_off: assert property (p_pin_off) // [RULE4]
        else $error("pin a driven while disabled");

    property p_pin_status;
        @(posedge clock) disable iff (!rstn)
        ctrl_r.mux_b == mux_status |=>
            status_pin_b_oe && status_pin_b_out == $past(status_b_func);
    endproperty
    a_pin_status: assert property (p_pin_status) // [RULE3]
        else $error("pin b status passthrough wrong");

    property p_pin_div0;
        @(posedge clock) disable iff (!rstn)
        ctrl_r.mux_a == mux_div0 |=> status_pin_a_out == $past(div0_level);
    endproperty
    a_pin_div0: assert property (p_pin_div0) // [RULE4]
        else $error("pin a does not follow divider 0");

    property p_reset_mux;
        @(posedge clock)
        !rstn |=> ctrl_r.mux_a == mux_status && ctrl_r.mux_b == mux_status;
    endproperty
    a_reset_mux: assert property (p_reset_mux) // [RULE3] [RULE4]
        else $error("source selects not reset to status");

    c_div0_tick: cover property (@(posedge clock) disable iff (!rstn)
        div0_tick && hd_ok_r);
    c_second_src: cover property (@(posedge clock) disable iff (!rstn)
        src_r && prediv_tick);
    c_pin_b_div1: cover property (@(posedge clock) disable iff (!rstn)
        ctrl_r.mux_b == mux_div1 && status_pin_b_oe);
endmodule // cmos_status_clock_divider

// ===== tb_cmos_status_clock_divider.sv
// self-checking bench for the status pin clock routing and divider 0
`timescale 1ns/1ps
module tb_cmos_status_clock_divider
    import cmos_clk_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic primary_tick = 1'b0;
    logic second_synthesizer_tick = 1'b0;
    logic div1_level = 1'b0;
    logic status_a_func = 1'b0;
    logic status_b_func = 1'b0;
    logic status_pin_a_out, status_pin_a_oe;
    logic status_pin_b_out, status_pin_b_oe;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h6e8cd782;
    // register model: what each mapped register should read back
    logic [7:0] shadow [logic [7:0]];

    cmos_status_clock_divider u_cmos_status_clock_divider (
        .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .primary_tick(primary_tick),
        .second_synthesizer_tick(second_synthesizer_tick),
        .div1_level(div1_level), .status_a_func(status_a_func),
        .status_b_func(status_b_func),
        .status_pin_a_out(status_pin_a_out),
        .status_pin_a_oe(status_pin_a_oe),
        .status_pin_b_out(status_pin_b_out),
        .status_pin_b_oe(status_pin_b_oe)
    );

    always #2 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // longest run is a few divider periods at ratio 256 times 4
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            tally_and_finish;
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // model of the divide chain: ratio of divider 0 for a programmed value
    function automatic int div_ratio(int v);
        return (v < 6) ? 6 : v + 1;
    endfunction

    task automatic chk8(logic [7:0] g, logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(logic g, logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask

    task automatic chkn(int g, int e);
        chk8(g[7:0], e[7:0]);
        chk8(g[15:8], e[15:8]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        if (a == src_offset)
            shadow[a] = {7'h00, d[0]};
        else if (a == ctrl_offset || a == div0_offset)
            shadow[a] = d;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk8(rdata, e);
    endtask

    task automatic do_reset;
        rstn = 1'b0;
        shadow[ctrl_offset] = ctrl_reset;
        shadow[div0_offset] = div0_reset;
        shadow[src_offset] = src_reset;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
    endtask

    // cycles spent until pin a reaches level v, bounded
    task automatic wait_lvl(logic v, output int n);
        n = 0;
        while (status_pin_a_out !== v && n < 3000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic measure(int p, int v);
        int n, hi, lo;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, lo);
        chkn(hi, (div_ratio(v) >> 1) * p);
        chkn(hi + lo, div_ratio(v) * p);
    endtask

    // pin a must sit at level v for 100 cycles once it has settled
    task automatic holds_level(logic v);
        int misses;
        misses = 0;
        repeat (8) @(posedge clock);
        repeat (100)
        begin
            @(posedge clock);
            #1;
            if (status_pin_a_out !== v)
                misses++;
        end
        chkn(misses, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    int pv[5] = '{1, 2, 1, 2, 1};
    int dv[5] = '{1, 5, 6, 7, 255};
    logic [7:0] r;
    logic fa, fb, d1;

    initial
    begin
        do_reset;
        rd_chk(ctrl_offset, 8'h0a);
        rd_chk(div0_offset, 8'h00);
        rd_chk(src_offset, 8'h00);
        rd_chk(8'h2f, 8'h00);
        repeat (4)
        begin
            r = 8'(xs());
            wr_reg(div0_offset, r);
            rd_chk(div0_offset, shadow[div0_offset]);
            wr_reg(ctrl_offset, {2'h0, 2'h1, r[3:0]});
            rd_chk(ctrl_offset, shadow[ctrl_offset]);
        end
        wr_reg(8'h2f, 8'h5a);
        rd_chk(8'h2f, 8'h00);
        // every pin mode with divider 0 running from primary ticks
        wr_reg(div0_offset, 8'h01);
        primary_tick <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(ctrl_offset, {4'h1, m[1:0], m[1:0]});
            repeat (2) @(posedge clock);
            repeat (20)
            begin
                r = 8'(xs());
                fa = r[0];
                fb = r[1];
                d1 = r[2];
                @(posedge clock);
                status_a_func <= fa;
                status_b_func <= fb;
                div1_level <= d1;
                @(posedge clock);
                #1;
                chk1(status_pin_a_oe, m != 3);
                chk1(status_pin_b_oe, m != 3);
                case (m)
                    0: chk1(status_pin_b_out, status_pin_a_out);
                    1: chk1(status_pin_a_out, d1);
                    2: chk1(status_pin_a_out, fa);
                    default: chk1(status_pin_a_out, 1'b0);
                endcase
                case (m)
                    1: chk1(status_pin_b_out, d1);
                    2: chk1(status_pin_b_out, fb);
                    3: chk1(status_pin_b_out, 1'b0);
                    default: ;
                endcase
            end
        end
        // periods across pre-divider codes and divider 0 values
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(div0_offset, dv[i][7:0]);
            wr_reg(ctrl_offset, {2'h0, pv[i][1:0], 4'h0});
            measure(pv[i] + 3, dv[i]);
        end
        wr_reg(div0_offset, 8'h00);
        holds_level(1'b0);
        wr_reg(div0_offset, 8'h06);
        wr_reg(ctrl_offset, 8'h13);
        holds_level(1'b0);
        wr_reg(ctrl_offset, 8'h00);
        holds_level(1'b0);
        // source select: only the chosen synthesizer may drive the chain;
        // with no selected ticks the freshly enabled divider sits high
        wr_reg(src_offset, 8'h01);
        wr_reg(ctrl_offset, 8'h10);
        holds_level(1'b1);
        second_synthesizer_tick <= 1'b1;
        measure(4, 6);
        // a second reset brings the registers back to their reset values
        do_reset;
        rd_chk(ctrl_offset, 8'h0a);
        rd_chk(div0_offset, 8'h00);
        rd_chk(src_offset, 8'h00);
        tally_and_finish;
    end
endmodule // tb_cmos_status_clock_divider
